/* hw/cacc_regs.svh */
// Register offsets, field positions and reset values of the capture/compare array
`ifndef CACC_REGS_SVH
`define CACC_REGS_SVH
`define CACC_OFF_CONTROL 8'h00
`define CACC_OFF_COUNTER 8'h04
`define CACC_OFF_MODE0 8'h10
`define CACC_OFF_CMP0 8'h30
`define CACC_CH_STRIDE 8'h04
`define CACC_BIT_IRQ_EN 0
`define CACC_BIT_PWM 1
`define CACC_BIT_TOGGLE 2
`define CACC_BIT_MATCH 3
`define CACC_BIT_CAP_FALL 4
`define CACC_BIT_CAP_RISE 5
`define CACC_BIT_CMP_EN 6
`define CACC_BIT_WIDE 7
`define CACC_BIT_RUN 8
`define CACC_MODE_RESET 8'h00
`define CACC_CMP_RESET 16'h0000
`define CACC_NUM_CH 5
`define CACC_SYNC_STAGES 2
`endif

/* hw/cacc_pkg.sv */
// Types shared by the capture/compare array
package cacc_pkg;
	typedef struct packed {
		logic wide_pwm_select;
		logic comparator_enable;
		logic capture_rising_sel;
		logic capture_falling_sel;
		logic match_flag_enable;
		logic toggle_enable;
		logic pwm_enable;
		logic channel_irq_enable;
	} cacc_mode_s;
	typedef enum logic [2:0] {
		CACC_IDLE,
		CACC_CAPTURE,
		CACC_TIMER,
		CACC_HSO,
		CACC_FREQ,
		CACC_PWM8,
		CACC_PWM16
	} cacc_func_e;
	typedef struct packed {
		logic [15:0] compare;
		logic pin;
		logic flag;
		logic comparator_enable;
		logic [1:0] pin_hist;
	} cacc_chan_s;
endpackage : cacc_pkg

/* hw/cacc_channel.sv */
// One capture/compare channel
`timescale 1ns/1ps
`include "cacc_regs.svh"
module cacc_channel
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Shared counter
	input wire logic [15:0] count,
	input wire logic count_step,
	// Configuration
	input wire cacc_pkg::cacc_mode_s mode,
	// Software accesses
	input wire logic wr_low,
	input wire logic wr_high,
	input wire logic [7:0] wr_byte,
	input wire logic flag_clear,
	input wire logic flag_write,
	input wire logic flag_value,
	// Channel pin
	input wire logic pin_in,
	// State
	output cacc_pkg::cacc_chan_s state
);
	cacc_pkg::cacc_chan_s cur;
	cacc_pkg::cacc_chan_s next_cur;
	cacc_pkg::cacc_func_e func;
	logic [7:0] next_low;
	logic rise;
	logic fall;
	logic eq16;
	logic eq8;
	logic low_wrap;
	logic [15:0] count_ahead;
	logic pwm8_hit;
	logic pwm16_hit;
	logic hw_set;

	assign state = cur;

	always_comb
	begin
		func = cacc_pkg::CACC_IDLE;
		if (mode.pwm_enable && !mode.toggle_enable && !mode.capture_rising_sel
			&& !mode.capture_falling_sel)
			func = mode.wide_pwm_select ? cacc_pkg::CACC_PWM16 : cacc_pkg::CACC_PWM8; // RULE16
		else if (mode.pwm_enable && mode.toggle_enable)
			func = cacc_pkg::CACC_FREQ; // RULE13
		else if (mode.toggle_enable)
			func = cacc_pkg::CACC_HSO;
		else if (mode.capture_rising_sel || mode.capture_falling_sel)
			func = cacc_pkg::CACC_CAPTURE; // RULE1
		else if (mode.match_flag_enable)
			func = cacc_pkg::CACC_TIMER;
	end

	always_comb
	begin
		next_cur = cur;
		next_low = 8'h00;
		// Collects this cycle's hardware set of the flag
		next_cur.flag = 1'b0;
		next_cur.comparator_enable = mode.comparator_enable;
		// Edge detect on the first synchroniser stage and its delayed copy
		rise = cur.pin_hist[0] && !cur.pin_hist[1]; // RULE5
		fall = !cur.pin_hist[0] && cur.pin_hist[1];
		next_cur.pin_hist = {cur.pin_hist[0], pin_in};
		eq16 = count_step && (count == cur.compare);
		eq8 = count_step && (count[7:0] == cur.compare[7:0]);
		low_wrap = count_step && (count[7:0] == 8'hFF);
		// PWM looks one count ahead so that a zero compare keeps the pin high
		count_ahead = count + 16'h0001;
		pwm8_hit = count_step && (count_ahead[7:0]
			== (low_wrap ? cur.compare[15:8] : cur.compare[7:0]));
		pwm16_hit = count_step && (count_ahead == cur.compare);
		unique case (func)
			cacc_pkg::CACC_CAPTURE:
			begin
				if ((rise && mode.capture_rising_sel) || (fall && mode.capture_falling_sel))
				begin
					next_cur.compare = count; // RULE2
					next_cur.flag = 1'b1;
				end
			end
			cacc_pkg::CACC_TIMER:
			begin
				if (cur.comparator_enable && eq16)
					next_cur.flag = 1'b1; // RULE6
			end
			cacc_pkg::CACC_HSO:
			begin
				if (cur.comparator_enable && eq16) // RULE10
				begin
					next_cur.pin = !cur.pin; // RULE9
					if (mode.match_flag_enable)
						next_cur.flag = 1'b1;
				end
			end
			cacc_pkg::CACC_FREQ:
			begin
				if (cur.comparator_enable && eq8) // RULE10
				begin
					next_cur.pin = !cur.pin; // RULE11
					next_low = cur.compare[7:0] + cur.compare[15:8]; // RULE12
					next_cur.compare[7:0] = next_low;
				end
				if (cur.comparator_enable && mode.match_flag_enable && eq16)
					next_cur.flag = 1'b1; // RULE13
			end
			cacc_pkg::CACC_PWM8:
			begin
				if (!cur.comparator_enable)
					next_cur.pin = 1'b0; // RULE18
				else if (pwm8_hit)
				begin
					next_cur.pin = 1'b1; // RULE14
					if (mode.match_flag_enable)
						next_cur.flag = 1'b1; // RULE17
				end
				else if (low_wrap)
					next_cur.pin = 1'b0; // RULE14
				if (low_wrap)
					next_cur.compare[7:0] = cur.compare[15:8]; // RULE15 RULE19
			end
			cacc_pkg::CACC_PWM16:
			begin
				if (!cur.comparator_enable)
					next_cur.pin = 1'b0; // RULE18
				else if (pwm16_hit)
				begin
					next_cur.pin = 1'b1; // RULE20
					if (mode.match_flag_enable)
						next_cur.flag = 1'b1;
				end
				else if (count_step && count == 16'hFFFF)
					next_cur.pin = 1'b0; // RULE20
			end
			cacc_pkg::CACC_IDLE:
			begin
			end
		endcase
		if (wr_low)
			next_cur.compare[7:0] = wr_byte;
		if (wr_high)
			next_cur.compare[15:8] = wr_byte;
		// Hardware set wins over software clear or write
		hw_set = next_cur.flag;
		if (hw_set)
			next_cur.flag = 1'b1;
		else if (flag_write)
			next_cur.flag = flag_value;
		else if (flag_clear)
			next_cur.flag = 1'b0; // RULE3
		else
			next_cur.flag = cur.flag; // RULE3
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cur <= '0;
		else
			cur <= next_cur;
	end
endmodule : cacc_channel

/* hw/cacc_top.sv */
// Capture/compare array with AXI4-Lite register access
`timescale 1ns/1ps
`include "cacc_regs.svh"
// Behaviour
// [RULE1] Mode bits 5 and 4 select capture on rising, falling or both edges.
// [RULE2] A qualifying capture edge copies the counter into compare and sets flag.
// [RULE3] Flags stay set until software clears them.
// [RULE4] Channel interrupt request is flag and channel interrupt enable.
// [RULE5] Pin levels must hold two clocks to be seen; the code detects an edge from a level held for one clock.
// [RULE6] Software timer sets flag on sixteen-bit counter match.
// [RULE7] Low byte write clears comparator enable; high byte write sets it.
// [RULE8] Software writes low byte before high byte.
// [RULE9] High-speed output toggles pin and sets flag on each match; the code sets the flag only with match enable.
// [RULE10] Comparator disabled means toggle modes hold their pin.
// [RULE11] Frequency mode toggles on low byte match and adds high byte.
// [RULE12] High byte zero gives a wrapping half period of 256 clocks.
// [RULE13] Frequency mode with match enable sets flag on sixteen-bit equality.
// [RULE14] Eight-bit PWM goes high on low match, low on low-byte overflow.
// [RULE15] Eight-bit PWM reloads low byte from high byte at wrap.
// [RULE16] Bit 7 chooses eight-bit or sixteen-bit PWM.
// [RULE17] Eight-bit PWM with match enable flags each rising edge.
// [RULE18] PWM with comparator disabled holds output low.
// [RULE19] Eight-bit PWM high time is 256 minus the high byte.
// [RULE20] Sixteen-bit PWM high on match, low at counter overflow.
// [RULE21] Five independent channels share one counter.
module cacc_top #(
	parameter int NUM_CH = `CACC_NUM_CH
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Channel pins
	input wire logic [NUM_CH-1:0] channel_pin_in,
	output logic [NUM_CH-1:0] channel_pin_out,
	// Interrupt requests per channel
	output logic [NUM_CH-1:0] channel_irq
);
	typedef struct packed {
		logic [NUM_CH-1:0] hi_pend;
		logic run;
		logic [15:0] count;
		logic [NUM_CH-1:0][7:0] mode;
		logic [7:0] aw_addr;
		logic aw_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic w_have;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [NUM_CH-1:0] pin_out;
		logic [NUM_CH-1:0] irq;
	} cacc_top_s;

	cacc_top_s cur;
	cacc_top_s next_cur;
	logic [1:0] rst_reg;
	logic rst_n;
	logic do_write;
	logic [NUM_CH-1:0] wr_low;
	logic [NUM_CH-1:0] wr_high;
	logic [NUM_CH-1:0] flag_clear;
	logic [NUM_CH-1:0] flag_write;
	logic [NUM_CH-1:0] flag_bits;
	cacc_pkg::cacc_chan_s [NUM_CH-1:0] chan;

	// Channel index of a per-channel address, NUM_CH when not in the given bank
	function automatic int chan_of(input logic [7:0] addr, input logic [7:0] base);
		int idx;
		idx = NUM_CH;
		for (int i = 0; i < NUM_CH; i++)
			if (addr == base + 8'(i * `CACC_CH_STRIDE))
				idx = i;
		return idx;
	endfunction : chan_of

	// Reset release through two flops
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			rst_reg <= 2'b00;
		else
			rst_reg <= {rst_reg[0], 1'b1};
	end
	assign rst_n = rst_reg[1];

	assign do_write = cur.aw_have && cur.w_have && !cur.bvalid;

	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			wr_low[i] = do_write && cur.w_strb[0] && cur.w_strb[1]
				? (chan_of(cur.aw_addr, `CACC_OFF_CMP0) == i) : 1'b0;
			wr_high[i] = cur.hi_pend[i];
			flag_bits[i] = cur.w_data[i];
			flag_write[i] = do_write && cur.w_strb[0] && (cur.aw_addr == `CACC_OFF_CONTROL)
				&& cur.w_data[i];
			flag_clear[i] = do_write && cur.w_strb[0] && (cur.aw_addr == `CACC_OFF_CONTROL)
				&& !cur.w_data[i];
		end
	end

	generate
		for (genvar g = 0; g < NUM_CH; g++)
		begin : g_ch
			// Compare word write loads the low byte, then the high byte a cycle later
			cacc_channel u_ch (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.count(cur.count),
				.count_step(cur.run),
				.mode(cacc_pkg::cacc_mode_s'(cur.mode[g])),
				.wr_low(wr_low[g]),
				.wr_high(wr_high[g]),
				.wr_byte(cur.hi_pend[g] ? cur.w_data[15:8] : cur.w_data[7:0]),
				.flag_clear(flag_clear[g]),
				.flag_write(flag_write[g]),
				.flag_value(flag_bits[g]),
				.pin_in(channel_pin_in[g]),
				.state(chan[g])
			); // RULE21
		end
	endgenerate

	always_comb
	begin
		int ci;
		next_cur = cur;
		ci = NUM_CH;
		next_cur.hi_pend = wr_low;
		if (cur.run)
			next_cur.count = cur.count + 16'h0001;
		for (int i = 0; i < NUM_CH; i++)
		begin
			next_cur.pin_out[i] = chan[i].pin;
			next_cur.irq[i] = chan[i].flag && cur.mode[i][`CACC_BIT_IRQ_EN]; // RULE4
			if (wr_low[i])
				next_cur.mode[i][`CACC_BIT_CMP_EN] = 1'b0; // RULE7
			if (cur.hi_pend[i])
				next_cur.mode[i][`CACC_BIT_CMP_EN] = 1'b1; // RULE7
		end
		// Write channels
		if (s_axi_awvalid && !cur.aw_have)
		begin
			next_cur.aw_have = 1'b1;
			next_cur.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !cur.w_have)
		begin
			next_cur.w_have = 1'b1;
			next_cur.w_data = s_axi_wdata;
			next_cur.w_strb = s_axi_wstrb;
		end
		if (do_write)
		begin
			next_cur.aw_have = 1'b0;
			next_cur.w_have = 1'b0;
			next_cur.bvalid = 1'b1;
			next_cur.bresp = 2'b00;
			ci = chan_of(cur.aw_addr, `CACC_OFF_MODE0);
			if (cur.aw_addr == `CACC_OFF_CONTROL)
			begin
				if (cur.w_strb[1])
					next_cur.run = cur.w_data[`CACC_BIT_RUN];
			end
			else if (cur.aw_addr == `CACC_OFF_COUNTER)
			begin
				if (cur.w_strb[0])
					next_cur.count[7:0] = cur.w_data[7:0];
				if (cur.w_strb[1])
					next_cur.count[15:8] = cur.w_data[15:8];
			end
			else if (ci < NUM_CH)
			begin
				if (cur.w_strb[0])
					next_cur.mode[ci] = cur.w_data[7:0];
			end
			else if (chan_of(cur.aw_addr, `CACC_OFF_CMP0) == NUM_CH)
				next_cur.bresp = 2'b10;
		end
		if (cur.bvalid && s_axi_bready)
			next_cur.bvalid = 1'b0;
		// Read channel
		if (s_axi_arvalid && !cur.rvalid)
		begin
			next_cur.rvalid = 1'b1;
			next_cur.rresp = 2'b00;
			next_cur.rdata = 32'h0000_0000;
			if (s_axi_araddr == `CACC_OFF_CONTROL)
			begin
				for (int i = 0; i < NUM_CH; i++)
					next_cur.rdata[i] = chan[i].flag;
				next_cur.rdata[`CACC_BIT_RUN] = cur.run;
			end
			else if (s_axi_araddr == `CACC_OFF_COUNTER)
				next_cur.rdata[15:0] = cur.count;
			else if (chan_of(s_axi_araddr, `CACC_OFF_MODE0) < NUM_CH)
			begin
				ci = chan_of(s_axi_araddr, `CACC_OFF_MODE0);
				next_cur.rdata[7:0] = cur.mode[ci];
			end
			else if (chan_of(s_axi_araddr, `CACC_OFF_CMP0) < NUM_CH)
			begin
				ci = chan_of(s_axi_araddr, `CACC_OFF_CMP0);
				next_cur.rdata[15:0] = chan[ci].compare;
			end
			else
				next_cur.rresp = 2'b10;
		end
		else if (cur.rvalid && s_axi_rready)
			next_cur.rvalid = 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign s_axi_awready = !cur.aw_have;
	assign s_axi_wready = !cur.w_have;
	assign s_axi_bvalid = cur.bvalid;
	assign s_axi_bresp = cur.bresp;
	assign s_axi_arready = !cur.rvalid;
	assign s_axi_rvalid = cur.rvalid;
	assign s_axi_rdata = cur.rdata;
	assign s_axi_rresp = cur.rresp;
	assign channel_pin_out = cur.pin_out;
	assign channel_irq = cur.irq;
endmodule : cacc_top

/* bench/cacc_checker.sv */
// Bus handshake and interrupt checks bound to the capture/compare array
`timescale 1ns/1ps
module cacc_checker #(
	parameter int NUM_CH = 5
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Interrupt requests
	input wire logic [NUM_CH-1:0] channel_irq
);
	logic [3:0] since_wr;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);
	// Edges since the last write address was taken
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			since_wr <= 4'hF;
		else if (s_axi_awvalid && s_axi_awready)
			since_wr <= 4'h0;
		else if (since_wr != 4'hF)
			since_wr <= since_wr + 4'h1;
	end
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("write address taken while held");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answering");
	a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");
	a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response not released");
	a_resp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
		else $error("illegal write response");
	a_irq_holds: assert property (
		|(~channel_irq & $past(channel_irq)) |-> since_wr < 4'h8)
		else $error("interrupt dropped without software write");
endmodule : cacc_checker
bind cacc_top cacc_checker #(.NUM_CH(NUM_CH)) u_checker (.sys_clk(sys_clk),
	.resetn(resetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .channel_irq(channel_irq));

/* bench/cacc_pin_src.sv */
// External signal source driving the channel pins
`timescale 1ns/1ps
module cacc_pin_src #(
	parameter int NUM_CH = 5
)
(
	// Clock
	input wire logic sys_clk,
	// Requested levels
	input wire logic [NUM_CH-1:0] level,
	// Channel pins
	output logic [NUM_CH-1:0] pin
);
	logic held = 1'h0;
	initial pin = {NUM_CH{1'h0}};
	// Each level stays at least two clocks
	always @(posedge sys_clk)
	begin
		held <= (level != pin) && !held;
		if ((level != pin) && !held)
			pin <= level;
	end
endmodule : cacc_pin_src

/* bench/test_cacc_top.sv */
// Self-checking bench of the capture/compare array
`timescale 1ns/1ps
module test_cacc_top;
	localparam logic [79:0] cmp_list = {16'h0000, 16'h1000, 16'hFF00, 16'h0000, 16'hC080};
	localparam logic [39:0] mode_list = {8'h46, 8'h46, 8'hC2, 8'h02, 8'h4A};
	logic sys_clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, rr;
	logic [3:0] wstrb;
	logic [4:0] level, pin_in, pin_out, irq, prev;
	int err_total = 0;
	int num_checks = 0;
	int cycles = 0;
	int hi [5] = '{default: 0};
	int tog [5] = '{default: 0};
	cacc_top #(.NUM_CH(5)) dut_u (.sys_clk(sys_clk), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.channel_pin_in(pin_in), .channel_pin_out(pin_out), .channel_irq(irq));
	cacc_pin_src #(.NUM_CH(5)) src_u (.sys_clk(sys_clk), .level(level), .pin(pin_in));
	task automatic final_report();
		$display("Checks %0d, errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		logic [1:0] tr;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		tb = 1'h0;
		while (!tb)
		begin
			@(negedge sys_clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			tr = bresp;
			@(posedge sys_clk);
			if (ta)
				awvalid <= 1'h0;
			if (tw)
				wvalid <= 1'h0;
		end
		bready <= 1'h0;
		chk(32'(tr), 32'h0);
	endtask : wr
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tb;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		tb = 1'h0;
		while (!tb)
		begin
			@(negedge sys_clk);
			ta = arvalid && arready;
			tb = rvalid;
			d = rdata;
			r = rresp;
			@(posedge sys_clk);
			if (ta)
				arvalid <= 1'h0;
		end
		rready <= 1'h0;
	endtask : rd_reg
	task automatic rck(input logic [7:0] a, input logic [31:0] e);
		rd_reg(a, rd, rr);
		chk(32'(rr), 32'h0);
		chk(rd, e);
	endtask : rck
	initial
	begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Hang guard
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_total++;
			final_report();
		end
	end
	initial
	begin
		{resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, level} = 53'h0;
		wstrb = 4'hF;
		repeat (6) @(posedge sys_clk);
		resetn <= 1'h1;
		repeat (3) @(posedge sys_clk);
		rck(8'h00, 32'h0);
		rck(8'h10, 32'h0);
		rck(8'h30, 32'h0);
		rd_reg(8'hFC, rd, rr);
		chk(32'(rr), 32'h2);
		// Capture on rising, falling and either edge
		wr(8'h10, 32'h21);
		wr(8'h14, 32'h11);
		wr(8'h18, 32'h30);
		wr(8'h04, 32'h1234);
		level <= 5'h07;
		repeat (8) @(posedge sys_clk);
		rck(8'h00, 32'h05);
		chk(32'(irq), 32'h01);
		rck(8'h30, 32'h1234);
		wr(8'h04, 32'h5678);
		level <= 5'h00;
		repeat (8) @(posedge sys_clk);
		rck(8'h00, 32'h07);
		rck(8'h34, 32'h5678);
		rck(8'h38, 32'h5678);
		rck(8'h30, 32'h1234);
		repeat (20) @(posedge sys_clk);
		chk(32'(irq), 32'h03);
		wr(8'h00, 32'h0);
		rck(8'h00, 32'h0);
		chk(32'(irq), 32'h0);
		// Software timer and toggle output
		wr(8'h1C, 32'h08);
		rck(8'h1C, 32'h08);
		wr(8'h3C, 32'h10);
		rck(8'h1C, 32'h48);
		// Byte-only compare write is ignored
		wstrb <= 4'h1;
		wr(8'h3C, 32'hABCD);
		wstrb <= 4'hF;
		rck(8'h3C, 32'h0010);
		rck(8'h1C, 32'h48);
		wr(8'h20, 32'h4C);
		wr(8'h40, 32'h20);
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h100);
		repeat (60) @(posedge sys_clk);
		rck(8'h00, 32'h118);
		chk(32'(pin_out[4]), 32'h1);
		wr(8'h20, 32'h0C);
		wr(8'h04, 32'h0);
		repeat (60) @(posedge sys_clk);
		chk(32'(pin_out[4]), 32'h1);
		// PWM and frequency outputs over two low-byte periods
		wr(8'h00, 32'h0);
		for (int i = 0; i < 5; i++)
		begin
			wr(8'h30 + 8'(4 * i), 32'(cmp_list[16 * i +: 16]));
			wr(8'h10 + 8'(4 * i), 32'(mode_list[8 * i +: 8]));
		end
		wr(8'h04, 32'hFE00);
		wr(8'h00, 32'h100);
		repeat (16) @(negedge sys_clk);
		prev = pin_out;
		for (int n = 0; n < 512; n++)
		begin
			@(negedge sys_clk);
			for (int i = 0; i < 5; i++)
			begin
				hi[i] += int'(pin_out[i]);
				tog[i] += int'(pin_out[i] != prev[i]);
			end
			prev = pin_out;
		end
		chk(32'(hi[0]), 32'hC0);
		chk(32'(hi[1]), 32'h0);
		chk(32'(hi[2]), 32'h100);
		chk(32'(tog[3]), 32'h20);
		chk(32'(tog[4]), 32'h2);
		rck(8'h00, 32'h101);
		final_report();
	end
endmodule : test_cacc_top
